// [irq_rst_pkg.sv]
/*
  Shared constants and types for the reset sequencer and vectored interrupt controller.
  Assumes a single 20 MHz clock and I/O addresses of six bits on a plain register port.
*/
`default_nettype none
package irq_rst_pkg;
  // register addresses
  localparam logic [5:0] ADDR_STATUS = 6'h3f;
  localparam logic [5:0] ADDR_STACK = 6'h3d;
  localparam logic [5:0] ADDR_EXT_MASK = 6'h3b;
  localparam logic [5:0] ADDR_EXT_FLAG = 6'h3a;
  localparam logic [5:0] ADDR_TMR_MASK = 6'h39;
  localparam logic [5:0] ADDR_TMR_FLAG = 6'h38;
  localparam logic [5:0] ADDR_MCU_CTRL = 6'h35;
  localparam logic [5:0] ADDR_AUX_IRQ = 6'h07;
  // field positions
  localparam int GIE_BIT = 7;
  localparam int EXT1_BIT = 7;
  localparam int EXT0_BIT = 6;
  localparam int TOV1_BIT = 7;
  localparam int OCF1_BIT = 6;
  localparam int ICF1_BIT = 3;
  localparam int TOV0_BIT = 1;
  localparam int AUX_EN_LSB = 4;
  localparam int ISC0_LSB = 0;
  localparam int ISC1_LSB = 2;
  localparam logic [7:0] MCU_CTRL_MASK = 8'h0f;
  // sources, lowest index is highest priority
  localparam int NUM_SRC = 10;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_EXT1 = 1;
  localparam int SRC_CAPT = 2;
  localparam int SRC_COMP1 = 3;
  localparam int SRC_OVF1 = 4;
  localparam int SRC_OVF0 = 5;
  localparam int SRC_AUX_LSB = 6;
  localparam int NUM_AUX = 4;
  localparam int PC_W = 10;
  localparam logic [PC_W-1:0] VEC_RESET = 10'h000;
  localparam logic [PC_W-1:0] VEC_FIRST = 10'h001;
  // external sense modes
  localparam logic [1:0] ISC_LOW = 2'h0;
  localparam logic [1:0] ISC_FALL = 2'h2;
  localparam logic [1:0] ISC_RISE = 2'h3;
  // reset values and stack step
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] SP_STEP = 8'h02;
  // start-up delay in watchdog oscillator cycles
  localparam int unsigned FAST_START_CYC = 256;
  localparam int unsigned SLOW_START_CYC = 16384;
  localparam int START_W = 15;
  // shortest external reset pulse
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned EXT_RESET_MIN_NS = 50;
  localparam int unsigned EXT_RESET_MIN_CYC = (EXT_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic {SEQ_HOLD, SEQ_RUN} seq_t;
endpackage : irq_rst_pkg
`default_nettype wire

// [startup_delay.sv]
/*
  Start-up delay timer counting watchdog oscillator ticks before the core may run.
  Assumes the tick input is a one-cycle pulse synchronous to i_mclk.
*/
`default_nettype none
module startup_delay #(
  parameter int unsigned FAST_CYC = irq_rst_pkg::FAST_START_CYC,
  parameter int unsigned SLOW_CYC = irq_rst_pkg::SLOW_START_CYC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // control
  input wire logic i_restart,
  input wire logic i_osc_tick,
  input wire logic i_fast_start_fuse,
  // status
  output logic o_done
);
  typedef struct packed {
    logic [irq_rst_pkg::START_W-1:0] cnt;
    logic done;
  } dly_t;

  dly_t s_ff;
  dly_t nxt_s;
  logic [irq_rst_pkg::START_W-1:0] limit;

  always_comb begin
    limit = i_fast_start_fuse ? irq_rst_pkg::START_W'(FAST_CYC - 1) : irq_rst_pkg::START_W'(SLOW_CYC - 1);
    nxt_s = s_ff;
    if (i_restart) begin
      nxt_s.cnt = '0;
      nxt_s.done = 1'b0;
    end else if (!s_ff.done && i_osc_tick) begin
      if (s_ff.cnt == limit) begin
        nxt_s.done = 1'b1;
      end else begin
        nxt_s.cnt = s_ff.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_done = s_ff.done;
endmodule : startup_delay
`default_nettype wire

// [irq_priority.sv]
/*
  Fixed-priority picker over the interrupt sources; lowest index wins.
  Assumes requests are already gated by their enables.
*/
`default_nettype none
module irq_priority (
  // requests
  input wire logic [irq_rst_pkg::NUM_SRC-1:0] i_req,
  // winner
  output logic o_any,
  output logic [3:0] o_idx
);
  always_comb begin
    o_any = |i_req;
    o_idx = 4'h0;
    for (int i = irq_rst_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (i_req[i]) begin
        o_idx = 4'(i);
      end
    end
  end
endmodule : irq_priority
`default_nettype wire

// [reset_and_interrupt_control.sv]
/*
  Reset sequencing and vectored interrupt arbitration, with status word, stack pointer,
  mask and flag registers on a plain register port.
  Assumes the core raises i_instr_boundary between instructions and pulses i_return_from_irq.
*/
`default_nettype none
// Notes on behaviour
// - ten sources plus reset; taken only with own enable and global enable set
// - vectors at lowest word addresses, reset first, comparator last
// - lower vector address has higher priority
// - any reset restores registers; execution starts at address zero
// - external reset pin low resets the device even without clock
// - start-up delay is 256 or 16K oscillator cycles by fast-start fuse
// - delay timer holds core after power-up; held pin extends it
// - delay starts counting when the external reset pin releases
// - watchdog gives one-cycle reset pulse; delay starts on its trailing edge
// - taking an interrupt clears global enable; return or software sets it
// - persistent conditions set their flag only on a new event
// - vectoring clears the flag of the served source
// - writing one clears a flag; writing zero leaves it
// - events with source disabled still set and hold the flag
// - flags pending while globally disabled are served by priority later
// - level-sensed external request has no flag, pending while pin low
// - status word is neither saved nor restored on entry or return
// - enables held in an external mask, a timer mask and the upper bits of the aux register
// - status bit 7 is global enable; zero blocks every interrupt
// - taking pushes return address, stack pointer minus two; return adds two
module reset_and_interrupt_control #(
  parameter int unsigned SLOW_START_CYC = irq_rst_pkg::SLOW_START_CYC
) (
  // clock and resets
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ext_reset_n,
  // start-up and watchdog
  input wire logic i_fast_start_fuse,
  input wire logic i_osc_tick,
  input wire logic i_wdt_timeout,
  // register port
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // core handshake
  input wire logic i_instr_boundary,
  input wire logic i_return_from_irq,
  output logic o_core_halt,
  output logic o_wdt_reset_pulse,
  output logic o_irq_take,
  output logic [irq_rst_pkg::PC_W-1:0] o_vector_addr,
  output logic [7:0] o_stack_ptr,
  output logic [7:0] o_status_word,
  // interrupt sources
  input wire logic i_external_request_zero,
  input wire logic i_external_request_one,
  input wire logic i_tmr1_capture,
  input wire logic i_tmr1_compare,
  input wire logic i_tmr1_overflow,
  input wire logic i_tmr0_overflow,
  input wire logic i_rx_complete,
  input wire logic i_tx_holding_empty,
  input wire logic i_tx_complete,
  input wire logic i_comparator_event
);
  localparam int N = irq_rst_pkg::NUM_SRC;

  typedef struct packed {
    irq_rst_pkg::seq_t seq;
    logic gie;
    logic [6:0] status_low;
    logic [7:0] sp;
    logic [3:0] isc;
    logic [N-1:0] en;
    logic [N-1:0] flag;
    logic [N-1:0] prev;
    logic wdt_pulse;
    logic take;
    logic [irq_rst_pkg::PC_W-1:0] vector;
    logic [7:0] rdata;
    logic halt;
  } ctl_t;

  ctl_t s_ff;
  ctl_t nxt_s;
  logic sys_rstn;
  logic start_done;
  logic any_req;
  logic [3:0] win_idx;
  logic [N-1:0] raw;
  logic [N-1:0] edge_evt;
  logic [N-1:0] level_req;
  logic [N-1:0] pending;

  // reset state of every register
  function automatic ctl_t reset_state();
    ctl_t r;
    r = '0;
    r.seq = irq_rst_pkg::SEQ_HOLD;
    r.sp = irq_rst_pkg::BYTE_RESET;
    r.vector = irq_rst_pkg::VEC_RESET;
    r.rdata = irq_rst_pkg::BYTE_RESET;
    r.halt = 1'b1;
    return r;
  endfunction : reset_state

  // source vector to register image: 0 ext, 1 timer, 2 aux
  function automatic logic [7:0] to_reg(input logic [N-1:0] v, input logic [1:0] sel);
    logic [7:0] b;
    b = irq_rst_pkg::BYTE_RESET;
    case (sel)
      2'h0: begin
        b[irq_rst_pkg::EXT0_BIT] = v[irq_rst_pkg::SRC_EXT0];
        b[irq_rst_pkg::EXT1_BIT] = v[irq_rst_pkg::SRC_EXT1];
      end
      2'h1: begin
        b[irq_rst_pkg::ICF1_BIT] = v[irq_rst_pkg::SRC_CAPT];
        b[irq_rst_pkg::OCF1_BIT] = v[irq_rst_pkg::SRC_COMP1];
        b[irq_rst_pkg::TOV1_BIT] = v[irq_rst_pkg::SRC_OVF1];
        b[irq_rst_pkg::TOV0_BIT] = v[irq_rst_pkg::SRC_OVF0];
      end
      default: begin
        b[irq_rst_pkg::NUM_AUX-1:0] = v[irq_rst_pkg::SRC_AUX_LSB +: irq_rst_pkg::NUM_AUX];
      end
    endcase
    return b;
  endfunction : to_reg

  // register image back to source positions
  function automatic logic [N-1:0] to_src(input logic [7:0] b, input logic [1:0] sel);
    logic [N-1:0] v;
    v = '0;
    case (sel)
      2'h0: begin
        v[irq_rst_pkg::SRC_EXT0] = b[irq_rst_pkg::EXT0_BIT];
        v[irq_rst_pkg::SRC_EXT1] = b[irq_rst_pkg::EXT1_BIT];
      end
      2'h1: begin
        v[irq_rst_pkg::SRC_CAPT] = b[irq_rst_pkg::ICF1_BIT];
        v[irq_rst_pkg::SRC_COMP1] = b[irq_rst_pkg::OCF1_BIT];
        v[irq_rst_pkg::SRC_OVF1] = b[irq_rst_pkg::TOV1_BIT];
        v[irq_rst_pkg::SRC_OVF0] = b[irq_rst_pkg::TOV0_BIT];
      end
      default: begin
        v[irq_rst_pkg::SRC_AUX_LSB +: irq_rst_pkg::NUM_AUX] = b[irq_rst_pkg::NUM_AUX-1:0];
      end
    endcase
    return v;
  endfunction : to_src

  // edge detection for one external pin
  function automatic logic pin_edge(input logic prev, input logic cur, input logic [1:0] mode);
    logic e;
    e = 1'b0;
    case (mode)
      irq_rst_pkg::ISC_FALL: e = prev & ~cur;
      irq_rst_pkg::ISC_RISE: e = ~prev & cur;
      default: e = 1'b0;
    endcase
    return e;
  endfunction : pin_edge

  // low-level sense mode of one external pin
  function automatic logic is_level(input logic [1:0] mode);
    return mode == irq_rst_pkg::ISC_LOW;
  endfunction : is_level

  // replace the enables of one register image, keep the rest
  function automatic logic [N-1:0] merge_en(input logic [N-1:0] en, input logic [7:0] b, input logic [1:0] sel);
    return (en & ~to_src(8'hff, sel)) | to_src(b, sel);
  endfunction : merge_en

  // stack pointer moves by one return address
  function automatic logic [7:0] sp_move(input logic [7:0] sp, input logic push);
    return push ? sp - irq_rst_pkg::SP_STEP : sp + irq_rst_pkg::SP_STEP;
  endfunction : sp_move

  assign sys_rstn = i_rstn & i_ext_reset_n;

  startup_delay #(
    .FAST_CYC(irq_rst_pkg::FAST_START_CYC),
    .SLOW_CYC(SLOW_START_CYC)
  ) u_startup (
    .i_mclk(i_mclk),
    .i_rstn(sys_rstn),
    .i_restart(s_ff.wdt_pulse),
    .i_osc_tick(i_osc_tick),
    .i_fast_start_fuse(i_fast_start_fuse),
    .o_done(start_done)
  );

  assign raw = {i_comparator_event, i_tx_complete, i_tx_holding_empty, i_rx_complete, i_tmr0_overflow,
    i_tmr1_overflow, i_tmr1_compare, i_tmr1_capture, i_external_request_one, i_external_request_zero};

  always_comb begin
    edge_evt = raw & ~s_ff.prev;
    edge_evt[irq_rst_pkg::SRC_EXT0] = pin_edge(s_ff.prev[irq_rst_pkg::SRC_EXT0], raw[irq_rst_pkg::SRC_EXT0],
      s_ff.isc[irq_rst_pkg::ISC0_LSB +: 2]);
    edge_evt[irq_rst_pkg::SRC_EXT1] = pin_edge(s_ff.prev[irq_rst_pkg::SRC_EXT1], raw[irq_rst_pkg::SRC_EXT1],
      s_ff.isc[irq_rst_pkg::ISC1_LSB +: 2]);
    level_req = '0;
    level_req[irq_rst_pkg::SRC_EXT0] = is_level(s_ff.isc[irq_rst_pkg::ISC0_LSB +: 2]) &
      ~raw[irq_rst_pkg::SRC_EXT0];
    level_req[irq_rst_pkg::SRC_EXT1] = is_level(s_ff.isc[irq_rst_pkg::ISC1_LSB +: 2]) &
      ~raw[irq_rst_pkg::SRC_EXT1];
    pending = (s_ff.flag | level_req) & s_ff.en;
  end

  irq_priority u_prio (
    .i_req(pending),
    .o_any(any_req),
    .o_idx(win_idx)
  );

  always_comb begin
    logic [N-1:0] sw_clr;
    logic [N-1:0] hw_clr;
    logic do_take;
    sw_clr = '0;
    hw_clr = '0;
    do_take = 1'b0;
    nxt_s = s_ff;
    nxt_s.take = 1'b0;
    nxt_s.wdt_pulse = 1'b0;
    nxt_s.prev = raw;
    nxt_s.rdata = irq_rst_pkg::BYTE_RESET;
    case (s_ff.seq)
      irq_rst_pkg::SEQ_HOLD: begin
        nxt_s = reset_state();
        nxt_s.prev = raw;
        if (start_done && !s_ff.wdt_pulse) begin
          nxt_s.seq = irq_rst_pkg::SEQ_RUN;
          nxt_s.halt = 1'b0;
        end
      end
      irq_rst_pkg::SEQ_RUN: begin
        // read data one cycle later
        if (i_rd) begin
          case (i_addr)
            irq_rst_pkg::ADDR_STATUS: nxt_s.rdata = {s_ff.gie, s_ff.status_low};
            irq_rst_pkg::ADDR_STACK: nxt_s.rdata = s_ff.sp;
            irq_rst_pkg::ADDR_EXT_MASK: nxt_s.rdata = to_reg(s_ff.en, 2'h0);
            irq_rst_pkg::ADDR_EXT_FLAG: nxt_s.rdata = to_reg(s_ff.flag, 2'h0);
            irq_rst_pkg::ADDR_TMR_MASK: nxt_s.rdata = to_reg(s_ff.en, 2'h1);
            irq_rst_pkg::ADDR_TMR_FLAG: nxt_s.rdata = to_reg(s_ff.flag, 2'h1);
            irq_rst_pkg::ADDR_MCU_CTRL: nxt_s.rdata = {4'h0, s_ff.isc};
            irq_rst_pkg::ADDR_AUX_IRQ: nxt_s.rdata = to_reg(s_ff.en, 2'h2) << irq_rst_pkg::AUX_EN_LSB |
              to_reg(s_ff.flag, 2'h2);
            default: nxt_s.rdata = irq_rst_pkg::BYTE_RESET;
          endcase
        end
        if (i_wr) begin
          case (i_addr)
            irq_rst_pkg::ADDR_STATUS: begin
              nxt_s.gie = i_wdata[irq_rst_pkg::GIE_BIT];
              nxt_s.status_low = i_wdata[irq_rst_pkg::GIE_BIT-1:0];
            end
            irq_rst_pkg::ADDR_STACK: nxt_s.sp = i_wdata;
            irq_rst_pkg::ADDR_EXT_MASK: begin
              nxt_s.en = merge_en(s_ff.en, i_wdata, 2'h0);
            end
            irq_rst_pkg::ADDR_TMR_MASK: begin
              nxt_s.en = merge_en(s_ff.en, i_wdata, 2'h1);
            end
            irq_rst_pkg::ADDR_AUX_IRQ: begin
              nxt_s.en = merge_en(s_ff.en, i_wdata >> irq_rst_pkg::AUX_EN_LSB, 2'h2);
              sw_clr = to_src(i_wdata, 2'h2);
            end
            irq_rst_pkg::ADDR_EXT_FLAG: sw_clr = to_src(i_wdata, 2'h0);
            irq_rst_pkg::ADDR_TMR_FLAG: sw_clr = to_src(i_wdata, 2'h1);
            irq_rst_pkg::ADDR_MCU_CTRL: nxt_s.isc = i_wdata[3:0] & irq_rst_pkg::MCU_CTRL_MASK[3:0];
            default: nxt_s.isc = nxt_s.isc;
          endcase
        end
        do_take = s_ff.gie && i_instr_boundary && any_req;
        if (do_take) begin
          nxt_s.vector = irq_rst_pkg::VEC_FIRST + irq_rst_pkg::PC_W'(win_idx);
          nxt_s.take = 1'b1;
          nxt_s.gie = 1'b0;
          nxt_s.sp = sp_move(s_ff.sp, 1'b1);
          hw_clr[win_idx] = 1'b1;
        end else if (i_return_from_irq) begin
          nxt_s.gie = 1'b1;
          nxt_s.sp = sp_move(s_ff.sp, 1'b0);
        end
        nxt_s.flag = (s_ff.flag & ~(sw_clr | hw_clr)) | edge_evt;
        if (is_level(s_ff.isc[irq_rst_pkg::ISC0_LSB +: 2])) begin
          nxt_s.flag[irq_rst_pkg::SRC_EXT0] = 1'b0;
        end
        if (is_level(s_ff.isc[irq_rst_pkg::ISC1_LSB +: 2])) begin
          nxt_s.flag[irq_rst_pkg::SRC_EXT1] = 1'b0;
        end
        if (i_wdt_timeout) begin
          nxt_s = reset_state();
          nxt_s.prev = raw;
          nxt_s.wdt_pulse = 1'b1;
        end
      end
      default: nxt_s = reset_state();
    endcase
  end

  always_ff @(posedge i_mclk or negedge sys_rstn) begin
    if (!sys_rstn) begin
      s_ff <= reset_state();
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_status_word = {s_ff.gie, s_ff.status_low};
  assign o_rdata = s_ff.rdata;
  assign o_core_halt = s_ff.halt;
  assign o_wdt_reset_pulse = s_ff.wdt_pulse;
  assign o_irq_take = s_ff.take;
  assign o_vector_addr = s_ff.vector;
  assign o_stack_ptr = s_ff.sp;
endmodule : reset_and_interrupt_control
`default_nettype wire

// [irq_rst_props.sv]
/*
  Concurrent checks on the reset and interrupt block's top ports.
  Assumes one clock; either reset input held low disables them.
*/
`default_nettype none
module irq_rst_props (
  // clock and resets
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ext_reset_n,
  // core and watchdog
  input wire logic i_wdt_timeout,
  input wire logic i_instr_boundary,
  input wire logic i_return_from_irq,
  input wire logic o_core_halt,
  input wire logic o_wdt_reset_pulse,
  input wire logic o_irq_take,
  input wire logic [irq_rst_pkg::PC_W-1:0] o_vector_addr,
  input wire logic [7:0] o_stack_ptr,
  input wire logic [7:0] o_status_word
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn || !i_ext_reset_n);
  sequence s_take;
    o_irq_take && !o_status_word[7] ##1 !o_irq_take;
  endsequence
  sequence s_wdt;
    o_wdt_reset_pulse && o_core_halt ##1 !o_wdt_reset_pulse && o_core_halt;
  endsequence
  a_take_clears_gie: assert property (o_irq_take |-> $past(o_status_word[7]) ##0 s_take)
    else $error("take without enable or enable left set");
  a_take_at_boundary: assert property (o_irq_take |-> $past(i_instr_boundary) && !$past(o_core_halt))
    else $error("take outside an instruction boundary");
  a_take_push: assert property (o_irq_take |-> o_stack_ptr == $past(o_stack_ptr) - 8'h02)
    else $error("stack pointer not lowered by two");
  a_return_pop: assert property (i_return_from_irq && !o_core_halt && !i_wdt_timeout |=>
    o_irq_take || (o_status_word[7] && o_stack_ptr == $past(o_stack_ptr) + 8'h02))
    else $error("return did not restore enable and pointer");
  a_vector_range: assert property (o_irq_take |-> o_vector_addr inside {[10'h001:10'h00a]})
    else $error("vector outside source range");
  a_wdt_pulse: assert property ($past(i_wdt_timeout) && !$past(o_core_halt) |-> s_wdt)
    else $error("watchdog pulse not one cycle");
  a_wdt_cause: assert property (o_wdt_reset_pulse |-> $past(i_wdt_timeout))
    else $error("reset pulse without watchdog expiry");
  a_wdt_clears: assert property (o_wdt_reset_pulse |-> o_status_word == 8'h00 && o_stack_ptr == 8'h00)
    else $error("registers not cleared by watchdog reset");
  a_halt_no_take: assert property (o_core_halt |-> !o_irq_take)
    else $error("take while core halted");
endmodule : irq_rst_props
`default_nettype wire

// [core_model.sv]
/*
  Behavioural core: marks instruction boundaries and returns from each handler.
  Assumes the take input is the block's one-cycle acceptance pulse.
*/
`default_nettype none
module core_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // bench control
  input wire logic i_slow,
  // block side
  input wire logic i_irq_take,
  output logic o_boundary,
  output logic o_ret
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cnt;
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_boundary <= 1'b0;
      o_ret <= 1'b0;
      wait_cnt <= 0;
    end else begin
      // boundary every cycle or every other
      o_boundary <= i_slow ? !o_boundary : 1'b1;
      o_ret <= 1'b0;
      if (i_irq_take) begin
        wait_cnt <= i_slow ? 6 : 2;
      end else if (wait_cnt == 1) begin
        o_ret <= 1'b1;
        wait_cnt <= 0;
      end else if (wait_cnt > 1) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule : core_model
`default_nettype wire

// [reset_and_interrupt_control_test.sv]
/*
  Self-checking bench for the reset and interrupt block with a core model.
  Assumes the design package is compiled first; the checker is bound below.
*/
`default_nettype none
module reset_and_interrupt_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] MA [10] = '{6'h3b, 6'h3b, 6'h39, 6'h39, 6'h39, 6'h39, 6'h07, 6'h07, 6'h07, 6'h07};
  localparam logic [7:0] MB [10] = '{8'h40, 8'h80, 8'h08, 8'h40, 8'h80, 8'h02, 8'h10, 8'h20, 8'h40, 8'h80};
  localparam logic [5:0] AD [8] = '{6'h3f, 6'h3d, 6'h3b, 6'h3a, 6'h39, 6'h38, 6'h35, 6'h07};
  logic i_mclk, i_rstn, i_ext_reset_n, i_fast_start_fuse, i_wdt_timeout;
  logic i_osc_tick = 1'b0;
  logic i_wr, i_rd, i_instr_boundary, i_return_from_irq, o_core_halt, o_wdt_reset_pulse, o_irq_take;
  logic [5:0] i_addr;
  logic [7:0] i_wdata, o_rdata, o_stack_ptr, o_status_word, sp, st;
  logic [9:0] o_vector_addr, src;
  logic slow, tick_en;
  logic rd_d = 1'b0;
  logic [9:0] vq [$];
  logic [7:0] rq [$];
  int mismatches, comparisons, nt, cyc, i;

  reset_and_interrupt_control #(.SLOW_START_CYC(16)) u_dut (
    .i_mclk, .i_rstn, .i_ext_reset_n, .i_fast_start_fuse, .i_osc_tick, .i_wdt_timeout,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_instr_boundary, .i_return_from_irq,
    .o_core_halt, .o_wdt_reset_pulse, .o_irq_take, .o_vector_addr, .o_stack_ptr, .o_status_word,
    .i_external_request_zero(src[0]), .i_external_request_one(src[1]), .i_tmr1_capture(src[2]),
    .i_tmr1_compare(src[3]), .i_tmr1_overflow(src[4]), .i_tmr0_overflow(src[5]),
    .i_rx_complete(src[6]), .i_tx_holding_empty(src[7]), .i_tx_complete(src[8]),
    .i_comparator_event(src[9]));
  core_model u_core (.i_mclk, .i_rstn, .i_slow(slow), .i_irq_take(o_irq_take),
    .o_boundary(i_instr_boundary), .o_ret(i_return_from_irq));

  task automatic end_sim;
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [5:0] a, logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask : wr
  task automatic rd(logic [5:0] a, logic [7:0] exp);
    rq.push_back(exp);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(posedge i_mclk);
  endtask : rd
  task automatic drain(int tail);
    int k;
    for (k = 0; k < 300 && vq.size() > 0; k++) @(negedge i_mclk);
    chk("pending", 16'(vq.size()), 16'h0000);
    @(posedge i_mclk);
    repeat (tail) @(posedge i_mclk);
  endtask : drain
  task automatic up(int n);
    int k;
    for (k = 0; k < 2000 && o_core_halt !== 1'b0; k++) @(negedge i_mclk);
    @(posedge i_mclk);
    chk("ticks", 16'(nt), 16'(n));
    chk("reset vector", 16'(o_vector_addr), 16'h0000);
    foreach (AD[j]) rd(AD[j], 8'h00);
  endtask : up
  task automatic su(logic f, bit wdt, int hold, int n);
    i_fast_start_fuse <= f;
    nt = 0;
    tick_en <= !wdt;
    repeat (2) @(posedge i_mclk);
    i_wdt_timeout <= wdt;
    i_ext_reset_n <= wdt;
    repeat (hold) @(posedge i_mclk);
    i_wdt_timeout <= 1'b0;
    @(negedge i_mclk);
    chk("halt", 16'(o_core_halt), 16'h0001);
    chk("wdt pulse", 16'(o_wdt_reset_pulse), 16'(wdt));
    @(posedge i_mclk);
    i_ext_reset_n <= 1'b1;
    nt = 0;
    tick_en <= 1'b1;
    up(n);
  endtask : su

  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  // tick source, start-up tick count, result watcher
  always @(posedge i_mclk) begin
    if (rd_d) chk("rdata", 16'(o_rdata), 16'(rq.pop_front()));
    if (o_irq_take) chk("vector", 16'(o_vector_addr), 16'(vq.size() ? vq.pop_front() : 10'h3ff));
    rd_d <= i_rd;
    i_osc_tick <= tick_en && (cyc % 3 == 0);
    if (i_osc_tick && o_core_halt && i_rstn && i_ext_reset_n) nt++;
    cyc++;
    if (cyc == 12000) begin
      mismatches++;
      end_sim;
    end
  end

  initial begin
    {i_rstn, i_fast_start_fuse, i_wdt_timeout, i_wr, i_rd, slow} = '0;
    {i_ext_reset_n, tick_en} = 2'b11;
    {i_addr, i_wdata, src} = '0;
    void'($urandom(32'h025da184));
    repeat (4) @(posedge i_mclk);
    i_rstn <= 1'b1;
    up(16);
    rd(6'h01, 8'h00);
    sp = 8'($urandom);
    st = {1'b1, 7'($urandom)};
    wr(6'h3d, sp);
    wr(6'h35, 8'h0f);
    for (i = 0; i < 10; i++) begin
      wr(MA[i], MB[i]);
      wr(6'h3f, st);
      vq.push_back(10'(i + 1));
      src[i] <= 1'b1;
      drain(12);
      rd(6'h3f, st);
      rd(6'h3d, sp);
      chk("stack", 16'(o_stack_ptr), 16'(sp));
      chk("status", 16'(o_status_word), 16'(st));
      wr(MA[i], 8'h00);
      src[i] <= 1'b0;
    end
    wr(6'h3f, 8'h00);
    wr(6'h3b, 8'hc0);
    wr(6'h39, 8'hca);
    wr(6'h07, 8'hf0);
    slow <= 1'b1;
    src <= 10'h3ff;
    repeat (8) @(posedge i_mclk);
    rd(6'h3a, 8'hc0);
    rd(6'h38, 8'hca);
    rd(6'h07, 8'hff);
    for (i = 1; i <= 10; i++) vq.push_back(10'(i));
    wr(6'h3f, 8'h80);
    drain(20);
    rd(6'h3a, 8'h00);
    rd(6'h38, 8'h00);
    rd(6'h07, 8'hf0);
    {slow, src} <= '0;
    wr(6'h39, 8'h00);
    src[5] <= 1'b1;
    repeat (2) @(posedge i_mclk);
    rd(6'h38, 8'h02);
    wr(6'h38, 8'hfd);
    rd(6'h38, 8'h02);
    vq.push_back(10'h006);
    wr(6'h39, 8'h02);
    drain(12);
    wr(6'h39, 8'h00);
    src[5] <= 1'b0;
    repeat (2) @(posedge i_mclk);
    src[5] <= 1'b1;
    repeat (2) @(posedge i_mclk);
    wr(6'h38, 8'h02);
    rd(6'h38, 8'h00);
    wr(6'h39, 8'h02);
    repeat (10) @(posedge i_mclk);
    wr(6'h3b, 8'h00);
    src <= 10'h001;
    wr(6'h35, 8'h0c);
    wr(6'h3b, 8'h40);
    repeat (6) @(posedge i_mclk);
    vq.push_back(10'h001);
    src[0] <= 1'b0;
    drain(0);
    src[0] <= 1'b1;
    rd(6'h3a, 8'h00);
    repeat (10) @(posedge i_mclk);
    su(1'b0, 1'b0, 2, 16);
    wr(6'h3d, sp);
    su(1'b1, 1'b0, 40, 256);
    wr(6'h3f, st);
    su(1'b0, 1'b1, 1, 16);
    end_sim;
  end
endmodule : reset_and_interrupt_control_test

bind reset_and_interrupt_control irq_rst_props u_props (.i_mclk, .i_rstn, .i_ext_reset_n,
  .i_wdt_timeout, .i_instr_boundary, .i_return_from_irq, .o_core_halt, .o_wdt_reset_pulse,
  .o_irq_take, .o_vector_addr, .o_stack_ptr, .o_status_word);
`default_nettype wire
